// >>> src/ssr_catch_hold.sv
// Purpose: bank of catch-and-hold bits with a clear
// Assumes: set and clear are synchronous to ref_clk
// Notes: CLEAR_WINS picks which side wins when both arrive together
`timescale 1ns/10ps
module ssr_catch_hold #(
  parameter int W = 4,
  parameter bit CLEAR_WINS = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [W-1:0] setIn,
  input wire logic [W-1:0] clrIn,
  output logic [W-1:0] holdOut
);
  logic [W-1:0] hold_reg;
  logic [W-1:0] hold_next;

  always_comb begin
    if (CLEAR_WINS) begin
      hold_next = (hold_reg | setIn) & ~clrIn;
    end else begin
      hold_next = (hold_reg & ~clrIn) | setIn;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_reg <= '0;
    end else begin
      hold_reg <= hold_next;
    end
  end

  assign holdOut = hold_reg;
endmodule // ssr_catch_hold

// >>> src/ssr_pkg.sv
// Purpose: shared constants for the supply status and readback block
// Assumes: 200 MHz ref_clk, register port with 8-bit byte addresses
// Notes: all offsets are byte addresses of 32-bit words
package ssr_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SETTLE_TIME_NS = 1000;
  // least time, rounded up to whole cycles
  localparam int SETTLE_CYC = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_W = 9;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_QUERY_CHAN = 8'h00;
  localparam logic [7:0] ADDR_QUERY_INPUT = 8'h04;
  localparam logic [7:0] ADDR_REPLY = 8'h08;
  localparam logic [7:0] ADDR_SEL_STATE = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_OWN_CHAN = 8'h18;
  localparam logic [7:0] ADDR_CTRL = 8'h1c;
  localparam logic [7:0] ADDR_FLAGS = 8'h20;
  localparam logic [7:0] ADDR_PANEL_READ = 8'h24;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int IRQ_W = 4;
  localparam int IRQ_QUERY_DONE = 0;
  localparam int IRQ_CROWBAR = 1;
  localparam int IRQ_REFUSED = 2;
  localparam int IRQ_COND = 3;
  localparam int CTRL_RESUME = 0;
  localparam logic [2:0] OWN_CHAN_RST = 3'h1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [15:0] REPLY_RST = 16'h0000;

  // ----------------------------------------
  // reply scaling, values in millivolts
  // ----------------------------------------
  localparam int POS_LIMIT_MV = 100;
  localparam int NEG_LIMIT_MV = -10000;
  localparam int GAIN_FRAC_MUL = 41;
  localparam int GAIN_FRAC_SHIFT = 12;
  localparam int NUM_INPUTS = 8;
endpackage

// >>> src/ssr_reply_scale.sv
// Purpose: turn a selector reading into the signed thousandths reply
// Assumes: reading is signed millivolts
// Notes: purely combinational
`timescale 1ns/10ps
module ssr_reply_scale (
  input wire logic [15:0] readingMv,
  output logic [15:0] replyOut
);
  logic signed [31:0] inMv;
  logic signed [31:0] clipped;
  logic signed [31:0] scaled;

  always_comb begin
    inMv = 32'(signed'(readingMv));
    clipped = (inMv < ssr_pkg::NEG_LIMIT_MV) ? 32'(ssr_pkg::NEG_LIMIT_MV) : inMv;
    // gain of -1.01 as x + x*41/4096, cheaper than a divider
    scaled = -(clipped + ((clipped * ssr_pkg::GAIN_FRAC_MUL) >>> ssr_pkg::GAIN_FRAC_SHIFT));
    // inputs above 100 mV all read as -0.100
    if (inMv > ssr_pkg::POS_LIMIT_MV) begin
      scaled = -32'(ssr_pkg::POS_LIMIT_MV);
    end
    // 2 mV resolution: drop the lowest bit
    replyOut = {scaled[15:1], 1'b0};
  end
endmodule // ssr_reply_scale

// >>> src/ssr_status_readback.sv
// Purpose: crowbar fire logic, status flag latches and readback selector
// Assumes: all inputs synchronous to ref_clk; converter answers with convValid
// Notes: flag pins are open collector, driven only low
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module ssr_status_readback (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic irqOut,
  input wire logic progLimitCompare,
  input wire logic progLimitInhibit,
  input wire logic fixedLimitTrip,
  output logic crowbarFireOut,
  output logic crowbarHighDrive,
  input wire logic constVoltCond,
  input wire logic posCurrentLimitCond,
  input wire logic negCurrentLimitCond,
  input wire logic lossOfRegCond,
  input wire logic excessVoltSense,
  input wire logic thermalSense,
  input wire logic flagClear,
  input wire logic flagSelectN,
  input wire logic [5:0] flagBusIn,
  output logic constVoltStatusOut,
  output logic constVoltStatusOe,
  output logic posLimitStatusOut,
  output logic posLimitStatusOe,
  output logic negLimitStatusOut,
  output logic negLimitStatusOe,
  output logic lossOfRegulationOut,
  output logic lossOfRegulationOe,
  output logic excessVoltageFlagOut,
  output logic excessVoltageFlagOe,
  output logic thermalFlagOut,
  output logic thermalFlagOe,
  output logic [7:0] muxRoute,
  output logic convStart,
  input wire logic convValid,
  input wire logic [15:0] convData,
  input wire logic panelConvReq,
  input wire logic [2:0] panelInputIdx,
  input wire logic [2:0] panelMonitorChan,
  input wire logic setpointKey,
  output logic [15:0] panelReading
);
  // ----------------------------------------
  // crowbar
  // ----------------------------------------
  // comparator path
  assign crowbarFireOut = (progLimitCompare & ~progLimitInhibit) | fixedLimitTrip;
  assign crowbarHighDrive = fixedLimitTrip;

  // ----------------------------------------
  // status latches
  // ----------------------------------------
  logic [3:0] condLatch, condSet;
  assign condSet = {lossOfRegCond, negCurrentLimitCond, posCurrentLimitCond, constVoltCond};

  ssr_catch_hold #(.W(4), .CLEAR_WINS(1'b1)) u_cond (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .setIn(condSet),
    .clrIn({4{flagClear}}),
    .holdOut(condLatch)
  );
  logic constVoltLatch, posLimitLatch, negLimitLatch, lossOfRegulationLatch;
  assign {lossOfRegulationLatch, negLimitLatch, posLimitLatch, constVoltLatch} = condLatch;
  // ----------------------------------------
  // open-collector flag pins
  // ----------------------------------------
  logic flagDrive;
  assign flagDrive = ~flagSelectN;

  assign lossOfRegulationOut = 1'b0;
  assign lossOfRegulationOe = flagDrive & lossOfRegulationLatch;
  assign negLimitStatusOut = 1'b0;
  assign negLimitStatusOe = flagDrive & negLimitLatch;
  assign constVoltStatusOut = 1'b0;
  assign constVoltStatusOe = flagDrive & constVoltLatch;
  assign posLimitStatusOut = 1'b0;
  assign posLimitStatusOe = flagDrive & posLimitLatch;
  assign excessVoltageFlagOut = 1'b0;
  assign excessVoltageFlagOe = flagDrive & excessVoltSense;
  assign thermalFlagOut = 1'b0;
  assign thermalFlagOe = flagDrive & thermalSense;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  logic wrChan, wrInput, wrStatus, wrMask, wrOwn, wrCtrl;
  assign wrChan = regWrite && (regAddr == ssr_pkg::ADDR_QUERY_CHAN);
  assign wrInput = regWrite && (regAddr == ssr_pkg::ADDR_QUERY_INPUT);
  assign wrStatus = regWrite && (regAddr == ssr_pkg::ADDR_IRQ_STATUS);
  assign wrMask = regWrite && (regAddr == ssr_pkg::ADDR_IRQ_MASK);
  assign wrOwn = regWrite && (regAddr == ssr_pkg::ADDR_OWN_CHAN);
  assign wrCtrl = regWrite && (regAddr == ssr_pkg::ADDR_CTRL);

  // ----------------------------------------
  // query and conversion sequencing
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONVERT} ssr_state_t;
  ssr_state_t state_reg, state_next;
  logic [2:0] selIdx_reg, selIdx_next;
  logic [2:0] qChan_reg, qChan_next;
  logic armed_reg, armed_next;
  logic fromHost_reg, fromHost_next;
  logic [ssr_pkg::SETTLE_W-1:0] settle_reg, settle_next;
  logic [15:0] reply_reg, reply_next;
  logic [15:0] panelRd_reg, panelRd_next;
  logic convStart_reg, convStart_next;
  logic hold_reg, hold_next;
  logic [2:0] ownChan_reg, ownChan_next;
  logic [15:0] scaledReply;
  logic [3:0] inputNo;
  logic hostStart, refused, internalOk, internalStart, queryDone;
  ssr_reply_scale u_scale (
    .readingMv(convData),
    .replyOut(scaledReply)
  );
  assign inputNo = regWdata[3:0];
  // channel must come before input number
  // numbers 1..8 only, for this channel only
  assign hostStart = wrInput && armed_reg && (qChan_reg == ownChan_reg) && (inputNo >= 4'h1)
    && (inputNo <= 4'h8) && (state_reg == ST_IDLE);
  assign refused = wrInput && !hostStart;
  // panel conversions only while this channel is monitored and no key hold
  assign internalOk = (panelMonitorChan == ownChan_reg) && !hold_reg;
  assign internalStart = panelConvReq && internalOk && (state_reg == ST_IDLE) && !wrInput;
  assign queryDone = (state_reg == ST_CONVERT) && convValid && fromHost_reg;
  always_comb begin
    state_next = state_reg;
    selIdx_next = selIdx_reg;
    qChan_next = wrChan ? regWdata[2:0] : qChan_reg;
    armed_next = wrChan ? 1'b1 : (wrInput ? 1'b0 : armed_reg);
    fromHost_next = fromHost_reg;
    settle_next = settle_reg;
    reply_next = reply_reg;
    panelRd_next = panelRd_reg;
    convStart_next = 1'b0;
    ownChan_next = wrOwn ? regWdata[2:0] : ownChan_reg;
    // hold set by key wins over the resume write
    hold_next = setpointKey | (hold_reg & ~(wrCtrl & regWdata[ssr_pkg::CTRL_RESUME]));
    unique case (state_reg)
      ST_IDLE: begin
        // selection changes only when a conversion starts
        if (hostStart) begin
          selIdx_next = 3'(inputNo - 4'h1);
          fromHost_next = 1'b1;
          settle_next = ssr_pkg::SETTLE_W'(ssr_pkg::SETTLE_CYC);
          state_next = ST_SETTLE;
        end else if (internalStart) begin
          selIdx_next = panelInputIdx;
          fromHost_next = 1'b0;
          settle_next = ssr_pkg::SETTLE_W'(ssr_pkg::SETTLE_CYC);
          state_next = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // let the analog path settle before converting
        if (settle_reg == ssr_pkg::SETTLE_W'(1)) begin
          convStart_next = 1'b1;
          state_next = ST_CONVERT;
        end else begin
          settle_next = settle_reg - ssr_pkg::SETTLE_W'(1);
        end
      end
      ST_CONVERT: begin
        if (convValid) begin
          if (fromHost_reg) begin
            reply_next = scaledReply;
          end else begin
            panelRd_next = scaledReply;
          end
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      selIdx_reg <= 3'h0;
      qChan_reg <= 3'h0;
      armed_reg <= 1'b0;
      fromHost_reg <= 1'b0;
      settle_reg <= '0;
      reply_reg <= ssr_pkg::REPLY_RST;
      panelRd_reg <= ssr_pkg::REPLY_RST;
      convStart_reg <= 1'b0;
      hold_reg <= 1'b0;
      ownChan_reg <= ssr_pkg::OWN_CHAN_RST;
    end else begin
      state_reg <= state_next;
      selIdx_reg <= selIdx_next;
      qChan_reg <= qChan_next;
      armed_reg <= armed_next;
      fromHost_reg <= fromHost_next;
      settle_reg <= settle_next;
      reply_reg <= reply_next;
      panelRd_reg <= panelRd_next;
      convStart_reg <= convStart_next;
      hold_reg <= hold_next;
      ownChan_reg <= ownChan_next;
    end
  end

  assign muxRoute = 8'h01 << selIdx_reg;
  assign convStart = convStart_reg;
  assign panelReading = panelRd_reg;

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [ssr_pkg::IRQ_W-1:0] irqStatus, irqEvent, mask_reg, mask_next;
  logic crowbarPrev_reg;
  logic [3:0] condPrev_reg;
  always_comb begin
    irqEvent = '0;
    irqEvent[ssr_pkg::IRQ_QUERY_DONE] = queryDone;
    irqEvent[ssr_pkg::IRQ_CROWBAR] = crowbarFireOut & ~crowbarPrev_reg;
    irqEvent[ssr_pkg::IRQ_REFUSED] = refused;
    irqEvent[ssr_pkg::IRQ_COND] = |(condLatch & ~condPrev_reg);
    mask_next = wrMask ? regWdata[ssr_pkg::IRQ_W-1:0] : mask_reg;
  end
  // a new event beats a same-cycle write-one-to-clear
  ssr_catch_hold #(.W(ssr_pkg::IRQ_W), .CLEAR_WINS(1'b0)) u_irq (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .setIn(irqEvent),
    .clrIn(wrStatus ? regWdata[ssr_pkg::IRQ_W-1:0] : '0),
    .holdOut(irqStatus)
  );

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= ssr_pkg::IRQ_MASK_RST;
      crowbarPrev_reg <= 1'b0;
      condPrev_reg <= 4'h0;
    end else begin
      mask_reg <= mask_next;
      crowbarPrev_reg <= crowbarFireOut;
      condPrev_reg <= condLatch;
    end
  end

  assign irqOut = |(irqStatus & mask_reg);

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  logic [31:0] rdata_reg, rdata_next;
  always_comb begin
    rdata_next = 32'h0;
    if (regRead) begin
      unique case (regAddr)
        ssr_pkg::ADDR_QUERY_CHAN: rdata_next = {29'h0, qChan_reg};
        ssr_pkg::ADDR_REPLY: rdata_next = {{16{reply_reg[15]}}, reply_reg};
        ssr_pkg::ADDR_SEL_STATE: rdata_next = {26'h0, armed_reg, hold_reg, state_reg != ST_IDLE, selIdx_reg};
        ssr_pkg::ADDR_IRQ_STATUS: rdata_next = {28'h0, irqStatus};
        ssr_pkg::ADDR_IRQ_MASK: rdata_next = {28'h0, mask_reg};
        ssr_pkg::ADDR_OWN_CHAN: rdata_next = {29'h0, ownChan_reg};
        ssr_pkg::ADDR_FLAGS: rdata_next = {22'h0, flagBusIn, condLatch};
        ssr_pkg::ADDR_PANEL_READ: rdata_next = {{16{panelRd_reg[15]}}, panelRd_reg};
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign regRdata = rdata_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  localparam int SettleLo = ssr_pkg::SETTLE_CYC + 1; // registered convStart lands one cycle late
  sequence s_host_start;
    hostStart;
  endsequence
  sequence s_conv_issued;
    ##SettleLo convStart;
  endsequence
  a_crowbar_compare: assert property (progLimitCompare && !progLimitInhibit |-> crowbarFireOut)
    else $error("comparator did not fire crowbar");
  a_crowbar_inhibit: assert property (progLimitInhibit && !fixedLimitTrip |-> !crowbarFireOut)
    else $error("inhibit failed to mask comparator");
  a_crowbar_fixed: assert property (fixedLimitTrip |-> crowbarFireOut && crowbarHighDrive)
    else $error("fixed trip did not fire crowbar");
  a_crowbar_event: assert property ($rose(crowbarFireOut) |=> irqStatus[ssr_pkg::IRQ_CROWBAR])
    else $error("crowbar fire not recorded");
  a_latch_capture: assert property (negCurrentLimitCond && !flagClear |=> negLimitLatch [*2] or flagClear)
    else $error("condition not held");
  a_latch_clear: assert property (flagClear |=> condLatch == 4'h0)
    else $error("latches not cleared");
  a_clear_priority: assert property (flagClear && lossOfRegCond |=> !lossOfRegulationOe)
    else $error("set beat clear");
  a_loss_of_regulation_out_pin: assert property (!flagSelectN && $past(lossOfRegCond) && !$past(flagClear) |-> lossOfRegulationOe)
    else $error("regulation-loss pin not driven");
  a_neg_pin: assert property (negLimitStatusOe |-> !flagSelectN && negLimitLatch && !negLimitStatusOut)
    else $error("negative-limit pin wrong");
  a_flags_drive: assert property (!flagSelectN && thermalSense |-> thermalFlagOe)
    else $error("thermal flag not on bus");
  a_flags_release: assert property (flagSelectN |-> !(constVoltStatusOe | posLimitStatusOe | negLimitStatusOe
    | lossOfRegulationOe | excessVoltageFlagOe | thermalFlagOe))
    else $error("flag pin driven while released");
  a_route_onehot: assert property ($onehot(muxRoute))
    else $error("selector route not one-hot");
  a_query_order: assert property (wrInput && !armed_reg |=> $stable(muxRoute)
    && irqStatus[ssr_pkg::IRQ_REFUSED])
    else $error("unordered query accepted");
  a_input_map: assert property (hostStart |=> muxRoute == (8'h01 << ($past(regWdata[3:0]) - 4'h1)))
    else $error("input number mapped wrong");
  a_query_conv: assert property (s_host_start |-> s_conv_issued)
    else $error("conversion not issued after settle");
  a_reply_res: assert property (queryDone |=> reply_reg[0] == 1'b0)
    else $error("reply finer than 2 mV");
  a_route_hold: assert property (state_reg != ST_IDLE |=> $stable(muxRoute))
    else $error("route changed mid conversion");
  a_panel_stop: assert property (panelMonitorChan != ownChan_reg || hold_reg |-> !internalStart)
    else $error("internal conversion while stopped");
endmodule // ssr_status_readback

// >>> verif/ssr_conv_model.sv
// Purpose: converter model answering conversion requests
// Assumes: convStart is a one-cycle pulse
// Notes: idle data line shows the inverted last value
`timescale 1ns/10ps
module ssr_conv_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic convStart,
  input wire logic [15:0] value,
  input wire logic slow,
  output logic convValid,
  output logic [15:0] convData
);
  int waitCount;
  initial begin
    convValid = 1'b0;
    convData = 16'h0000;
    forever begin
      @(posedge ref_clk);
      #1;
      if (rstn && convStart) begin
        // slow answers keep the selector settled longer
        waitCount = slow ? 40 : 1;
        repeat (waitCount) @(posedge ref_clk);
        convValid <= 1'b1;
        convData <= value;
        @(posedge ref_clk);
        convValid <= 1'b0;
        convData <= ~value;
      end
    end
  end
endmodule // ssr_conv_model

// >>> verif/supply_status_and_readback_mux_tb_top.sv
// Purpose: self-checking bench for the status and readback block
// Assumes: converter model on the far side of the selector
// Notes: expected replies come from an integer model
`timescale 1ns/10ps
module supply_status_and_readback_mux_tb_top;
  logic ref_clk, rstn, regWrite, regRead, irqOut, crowbarFireOut, crowbarHighDrive, convStart, convValid;
  logic progLimitCompare, progLimitInhibit, fixedLimitTrip, flagClear, flagSelectN, panelConvReq, setpointKey;
  logic constVoltCond, posCurrentLimitCond, negCurrentLimitCond, lossOfRegCond, excessVoltSense, thermalSense;
  logic constVoltStatusOut, posLimitStatusOut, negLimitStatusOut, lossOfRegulationOut, excessVoltageFlagOut;
  logic thermalFlagOut, constVoltStatusOe, posLimitStatusOe, negLimitStatusOe, lossOfRegulationOe;
  logic excessVoltageFlagOe, thermalFlagOe, slow;
  logic [7:0] regAddr, muxRoute;
  logic [31:0] regWdata, regRdata, rdVal;
  logic [5:0] flagBusIn, oe, outs;
  logic [2:0] panelInputIdx, panelMonitorChan;
  logic [15:0] convData, panelReading, convValue, seed;
  int failures, check_count, cycles, n, x;
  assign oe = {thermalFlagOe, excessVoltageFlagOe, lossOfRegulationOe, negLimitStatusOe, posLimitStatusOe,
    constVoltStatusOe};
  assign outs = {thermalFlagOut, excessVoltageFlagOut, lossOfRegulationOut, negLimitStatusOut, posLimitStatusOut,
    constVoltStatusOut};
  ssr_status_readback u_dut (.ref_clk, .rstn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .irqOut,
    .progLimitCompare, .progLimitInhibit, .fixedLimitTrip, .crowbarFireOut, .crowbarHighDrive, .constVoltCond,
    .posCurrentLimitCond, .negCurrentLimitCond, .lossOfRegCond, .excessVoltSense, .thermalSense, .flagClear,
    .flagSelectN, .flagBusIn, .constVoltStatusOut, .constVoltStatusOe, .posLimitStatusOut, .posLimitStatusOe,
    .negLimitStatusOut, .negLimitStatusOe, .lossOfRegulationOut, .lossOfRegulationOe, .excessVoltageFlagOut,
    .excessVoltageFlagOe, .thermalFlagOut, .thermalFlagOe, .muxRoute, .convStart, .convValid, .convData,
    .panelConvReq, .panelInputIdx, .panelMonitorChan, .setpointKey, .panelReading);
  ssr_conv_model u_conv (.ref_clk, .rstn, .convStart, .value(convValue), .slow, .convValid, .convData);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // inputs above 100 mV read as a fixed small negative value
  function automatic logic [31:0] modelReply(input int v);
    int r;
    if (v > 100) r = -100;
    else begin
      if (v < -10000) v = -10000;
      r = -(v + ((v * 41) >>> 12));
      r = r & ~1;
    end
    return r;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 rdVal = regRdata;
    chk(rdVal, exp);
  endtask
  task automatic waitConv();
    n = 0;
    while (convValid !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(n < 400, 1'b1);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic results();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      results();
    end
  end
  initial begin
    {rstn, regWrite, regRead, progLimitCompare, progLimitInhibit, fixedLimitTrip, flagClear} = 7'h00;
    {constVoltCond, posCurrentLimitCond, negCurrentLimitCond, lossOfRegCond} = 4'h0;
    {excessVoltSense, thermalSense, panelConvReq, setpointKey, slow} = 5'h00;
    flagSelectN = 1'b1;
    {regAddr, regWdata, convValue, panelInputIdx} = '0;
    panelMonitorChan = 3'h1;
    seed = 16'h0061;
    flagBusIn = seed[5:0];
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    rchk(ssr_pkg::ADDR_IRQ_MASK, 32'h0);
    rchk(ssr_pkg::ADDR_OWN_CHAN, 32'h1);
    rchk(8'h3c, 32'h0);
    chk(muxRoute, 8'h01);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      {progLimitCompare, progLimitInhibit, fixedLimitTrip} <= 3'(i);
      @(posedge ref_clk);
      #1 chk(crowbarFireOut, (i[2] & ~i[1]) | i[0]);
      chk(crowbarHighDrive, i[0]);
    end
    $display("crowbar test done");
    seed = lfsr(seed);
    @(posedge ref_clk);
    {lossOfRegCond, negCurrentLimitCond, posCurrentLimitCond, constVoltCond} <= ~seed[3:0];
    {thermalSense, excessVoltSense} <= ~seed[5:4];
    flagSelectN <= 1'b0;
    @(posedge ref_clk);
    {lossOfRegCond, negCurrentLimitCond, posCurrentLimitCond, constVoltCond} <= 4'h0;
    repeat (2) @(posedge ref_clk);
    #1 chk(oe, 6'(~seed[5:0]));
    chk(outs, 6'h00);
    flagSelectN <= 1'b1;
    @(posedge ref_clk);
    #1 chk(oe, 6'h00);
    {flagClear, constVoltCond, lossOfRegCond, flagSelectN} <= 4'he;
    repeat (2) @(posedge ref_clk);
    {flagClear, constVoltCond, lossOfRegCond} <= 3'h0;
    {thermalSense, excessVoltSense} <= 2'h0;
    @(posedge ref_clk);
    #1 chk(oe, 6'h00);
    rchk(ssr_pkg::ADDR_FLAGS, {22'h0, flagBusIn, 4'h0});
    chk(irqOut, 1'b0);
    wr(ssr_pkg::ADDR_IRQ_MASK, 32'h2);
    #1 chk(irqOut, 1'b1);
    wr(ssr_pkg::ADDR_IRQ_STATUS, 32'hf);
    wr(ssr_pkg::ADDR_IRQ_MASK, 32'h1);
    #1 chk(irqOut, 1'b0);
    $display("flag test done");
    for (int i = 0; i < 4; i++) begin
      if (i > 0) wr(ssr_pkg::ADDR_QUERY_CHAN, (i == 3) ? 32'h2 : 32'h1);
      wr(ssr_pkg::ADDR_QUERY_INPUT, (i == 1) ? 32'h0 : (i == 2) ? 32'h9 : 32'h3);
      rchk(ssr_pkg::ADDR_IRQ_STATUS, 32'h4);
      chk(muxRoute, 8'h01);
      wr(ssr_pkg::ADDR_IRQ_STATUS, 32'h4);
    end
    rchk(ssr_pkg::ADDR_QUERY_CHAN, 32'h2);
    $display("refusal test done");
    for (int i = 1; i <= 8; i++) begin
      seed = lfsr(seed);
      x = (i == 2) ? 500 : (i == 4) ? -12000 : -int'(seed % 16'd10001);
      convValue <= 16'(x);
      slow <= seed[0];
      wr(ssr_pkg::ADDR_QUERY_CHAN, 32'h1); // channel first
      wr(ssr_pkg::ADDR_QUERY_INPUT, i); // then input
      @(posedge ref_clk);
      #1 chk(muxRoute, 8'h01 << (i - 1));
      waitConv();
      chk(irqOut, 1'b1);
      rchk(ssr_pkg::ADDR_REPLY, modelReply(x));
      chk(muxRoute, 8'h01 << (i - 1));
      wr(ssr_pkg::ADDR_IRQ_STATUS, 32'hf);
    end
    $display("query test done");
    {setpointKey, panelInputIdx} <= 4'hd;
    @(posedge ref_clk);
    {setpointKey, panelConvReq} <= 2'h1;
    @(posedge ref_clk);
    panelConvReq <= 1'b0;
    repeat (250) @(posedge ref_clk);
    #1 chk(muxRoute, 8'h80);
    rchk(ssr_pkg::ADDR_SEL_STATE, 32'h17);
    wr(ssr_pkg::ADDR_CTRL, 32'h1);
    convValue <= 16'hfc18;
    panelConvReq <= 1'b1;
    @(posedge ref_clk);
    panelConvReq <= 1'b0;
    @(posedge ref_clk);
    #1 chk(muxRoute, 8'h20);
    waitConv();
    chk(panelReading, modelReply(-1000) & 32'hffff);
    {panelMonitorChan, panelInputIdx, panelConvReq} <= 7'h41;
    @(posedge ref_clk);
    panelConvReq <= 1'b0;
    repeat (250) @(posedge ref_clk);
    #1 chk(muxRoute, 8'h20);
    $display("panel test done");
    results();
  end
endmodule // supply_status_and_readback_mux_tb_top
